// file: rtl/tsfc_pkg.sv
// constants and helpers shared by the translation service function control block
package tsfc_pkg;

   // ****************************************
   // bus geometry
   // ****************************************
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned STRB_W = DATA_W / 8;

   // ****************************************
   // register byte offsets
   // ****************************************
   localparam logic [ADDR_W-1:0] OFS_PART = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_FCTL = 8'h04;

   // ****************************************
   // bus responses
   // ****************************************
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ****************************************
   // partition register layout
   // ****************************************
   localparam int unsigned PART_PG_BIT  = 16;
   localparam int unsigned PART_ID_LSB  = 0;
   localparam int unsigned PART_ID_W    = 9;
   localparam logic [31:0] PART_MASK    = 32'h0001_01ff;
   localparam logic [31:0] PART_RESET   = 32'h0000_0000;

   // ****************************************
   // function control register layout
   // ****************************************
   localparam int unsigned FC_ACD_BIT   = 31;
   localparam int unsigned FC_PWR_BIT   = 30;
   localparam int unsigned FC_NCR_LSB   = 20;
   localparam int unsigned FC_NCR_W     = 4;
   localparam int unsigned FC_EVF_BIT   = 18;
   localparam int unsigned FC_DVF_BIT   = 17;
   localparam int unsigned FC_CLF_BIT   = 16;
   localparam int unsigned FC_LLC_LSB   = 12;
   localparam int unsigned FC_LLC_W     = 2;
   localparam int unsigned FC_PCE_BIT   = 11;
   localparam logic [31:0] FC_MASK      = 32'hc0f0_3800;
   localparam logic [31:0] FC_IDLE_ONLY = 32'h8000_0000;
   localparam logic [31:0] FC_RESET     = 32'h0000_0000;

   // byte-lane merge of a write into a stored word
   function automatic logic [DATA_W-1:0] wmerge(
      input logic [DATA_W-1:0] old_v,
      input logic [DATA_W-1:0] new_v,
      input logic [STRB_W-1:0] strb
   );
      logic [DATA_W-1:0] r;
      r = old_v;
      for (int i = 0; i < STRB_W; i++)
      begin
         if (strb[i])
         begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

endpackage

// file: rtl/tsfc_flush_track.sv
// self-clearing invalidation tracker for one cache
`timescale 1ns/1ns
module tsfc_flush_track
(
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // control
   input  wire logic start,
   input  wire logic done,
   // status
   output logic      busy_q,
   output logic      req_q
);

   // ****************************************
   // request pulse and busy flag
   // ****************************************
   // a start in the cycle the cache finishes opens a new round
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         busy_q <= 1'b0;
         req_q  <= 1'b0;
      end
      else
      begin
         req_q <= start && (!busy_q || done);
         if (start)
         begin
            busy_q <= 1'b1;
         end
         else if (done)
         begin
            busy_q <= 1'b0;
         end
      end
   end

endmodule

// file: rtl/tsfc_axil_slave.sv
// axi4-lite slave front end with one-cycle register access strobes
`timescale 1ns/1ns
module tsfc_axil_slave
(
   // clock and reset
   input  wire logic                         aclk,
   input  wire logic                         aresetn,
   // write address and data
   input  wire logic [tsfc_pkg::ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic                         s_axi_awvalid,
   output logic                              s_axi_awready,
   input  wire logic [tsfc_pkg::DATA_W-1:0]  s_axi_wdata,
   input  wire logic [tsfc_pkg::STRB_W-1:0]  s_axi_wstrb,
   input  wire logic                         s_axi_wvalid,
   output logic                              s_axi_wready,
   // write response
   output logic [1:0]                        s_axi_bresp,
   output logic                              s_axi_bvalid,
   input  wire logic                         s_axi_bready,
   // read
   input  wire logic [tsfc_pkg::ADDR_W-1:0]  s_axi_araddr,
   input  wire logic                         s_axi_arvalid,
   output logic                              s_axi_arready,
   output logic [tsfc_pkg::DATA_W-1:0]       s_axi_rdata,
   output logic [1:0]                        s_axi_rresp,
   output logic                              s_axi_rvalid,
   input  wire logic                         s_axi_rready,
   // register side
   output logic                              wr_en,
   output logic [tsfc_pkg::ADDR_W-1:0]       wr_addr,
   output logic [tsfc_pkg::DATA_W-1:0]       wr_data,
   output logic [tsfc_pkg::STRB_W-1:0]       wr_strb,
   input  wire logic                         wr_ok,
   output logic                              rd_en,
   output logic [tsfc_pkg::ADDR_W-1:0]       rd_addr,
   input  wire logic [tsfc_pkg::DATA_W-1:0]  rd_data,
   input  wire logic                         rd_ok
);
   import tsfc_pkg::*;

   logic [ADDR_W-1:0] awaddr_q;
   logic [DATA_W-1:0] wdata_q;
   logic [STRB_W-1:0] wstrb_q;

   assign wr_en   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign wr_addr = awaddr_q;
   assign wr_data = wdata_q;
   assign wr_strb = wstrb_q;
   assign rd_en   = s_axi_arvalid && s_axi_arready;
   assign rd_addr = s_axi_araddr;

   // ****************************************
   // write channels
   // ****************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         awaddr_q      <= '0;
         wdata_q       <= '0;
         wstrb_q       <= '0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awaddr_q      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_en)
         begin
            s_axi_bvalid  <= 1'b1;
            s_axi_bresp   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ****************************************
   // read channels
   // ****************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end
      else if (rd_en)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_ok ? rd_data : '0;
         s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule

// file: rtl/tsfc_top.sv
// partition select and function control registers of the translation service
// What this block does
// - partition register bit 16 drives the monitoring group on every memory access.
// - partition register bits 8:0 drive the partition id on every access.
// - settings act on this chip's service only, never forwarded elsewhere.
// - idle-only fields ignore writes unless the idle flag reads 1.
// - bit 31 picks direct (1) or translation-unit (0) attribute mapping; idle-only.
// - bit 30 asks the idle flag to report power-down readiness.
// - bits 23:20 set normal credits; zero means configured count plus one.
// - writing 1 to bit 18 flushes event cache; reads busy incl. base writes.
// - writing 1 to bit 17 flushes device cache; reads busy incl. base writes.
// - writing 1 to bit 16 flushes collection cache; reads busy incl. base writes.
// - bits 13:12 set low-latency credits; zero means configured count.
// - bit 11 enables poison checking on the coherent subordinate port.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
module tsfc_top
#(
   parameter logic [3:0] CFG_CREDIT    = 4'h7,
   parameter logic [1:0] CFG_LL_CREDIT = 2'h1
)
(
   // clock and reset
   input  wire logic                         aclk,
   input  wire logic                         aresetn,
   // axi4-lite write
   input  wire logic [tsfc_pkg::ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic                         s_axi_awvalid,
   output logic                              s_axi_awready,
   input  wire logic [tsfc_pkg::DATA_W-1:0]  s_axi_wdata,
   input  wire logic [tsfc_pkg::STRB_W-1:0]  s_axi_wstrb,
   input  wire logic                         s_axi_wvalid,
   output logic                              s_axi_wready,
   output logic [1:0]                        s_axi_bresp,
   output logic                              s_axi_bvalid,
   input  wire logic                         s_axi_bready,
   // axi4-lite read
   input  wire logic [tsfc_pkg::ADDR_W-1:0]  s_axi_araddr,
   input  wire logic                         s_axi_arvalid,
   output logic                              s_axi_arready,
   output logic [tsfc_pkg::DATA_W-1:0]       s_axi_rdata,
   output logic [1:0]                        s_axi_rresp,
   output logic                              s_axi_rvalid,
   input  wire logic                         s_axi_rready,
   // service status
   input  wire logic                         idle_flag,
   input  wire logic                         base0_wr,
   input  wire logic                         base1_wr,
   input  wire logic                         event_flush_done,
   input  wire logic                         device_flush_done,
   input  wire logic                         collection_flush_done,
   // memory access attributes
   output logic [tsfc_pkg::PART_ID_W-1:0]    partition_id,
   output logic                              perf_group,
   output logic                              attr_conversion_disable,
   // service control
   output logic                              powerdown_request,
   output logic [tsfc_pkg::FC_NCR_W:0]       normal_credit_init,
   output logic [tsfc_pkg::FC_LLC_W-1:0]     low_latency_credit_init,
   output logic                              poison_check_en,
   // cache invalidation requests
   output logic                              event_flush_req,
   output logic                              device_flush_req,
   output logic                              collection_flush_req
);
   import tsfc_pkg::*;

   // ****************************************
   // declarations
   // ****************************************
   logic              wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic [STRB_W-1:0] wr_strb;
   logic              wr_ok;
   logic              rd_en;
   logic [ADDR_W-1:0] rd_addr;
   logic [DATA_W-1:0] rd_data;
   logic              rd_ok;
   logic [DATA_W-1:0] part_q;
   logic [DATA_W-1:0] part_d;
   logic [DATA_W-1:0] fctl_q;
   logic [DATA_W-1:0] fctl_d;
   logic [DATA_W-1:0] fctl_keep;
   logic              fctl_wr;
   logic              ev_start;
   logic              dv_start;
   logic              cl_start;
   logic              ev_busy;
   logic              dv_busy;
   logic              cl_busy;

   // ****************************************
   // bus front end
   // ****************************************
   tsfc_axil_slave u_bus
   (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .wr_en         (wr_en),
      .wr_addr       (wr_addr),
      .wr_data       (wr_data),
      .wr_strb       (wr_strb),
      .wr_ok         (wr_ok),
      .rd_en         (rd_en),
      .rd_addr       (rd_addr),
      .rd_data       (rd_data),
      .rd_ok         (rd_ok)
   );

   assign wr_ok   = (wr_addr == OFS_PART) || (wr_addr == OFS_FCTL);
   assign rd_ok   = (rd_addr == OFS_PART) || (rd_addr == OFS_FCTL);
   assign fctl_wr = wr_en && (wr_addr == OFS_FCTL);

   // ****************************************
   // partition select register
   // ****************************************
   assign part_d = wmerge(part_q, wr_data, wr_strb) & PART_MASK;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         part_q <= PART_RESET;
      end
      else if (wr_en && (wr_addr == OFS_PART))
      begin
         part_q <= part_d;
      end
   end

   // ****************************************
   // function control register
   // ****************************************
   // idle-only bits keep their value while the service is busy
   assign fctl_keep = idle_flag ? '0 : FC_IDLE_ONLY;
   assign fctl_d    = ((wmerge(fctl_q, wr_data, wr_strb) & ~fctl_keep)
                      | (fctl_q & fctl_keep)) & FC_MASK;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         fctl_q <= FC_RESET;
      end
      else if (fctl_wr)
      begin
         fctl_q <= fctl_d;
      end
   end

   // ****************************************
   // cache invalidation trackers
   // ****************************************
   assign ev_start = (fctl_wr && wr_strb[2] && wr_data[FC_EVF_BIT]) || base0_wr;
   assign dv_start = (fctl_wr && wr_strb[2] && wr_data[FC_DVF_BIT]) || base0_wr;
   assign cl_start = (fctl_wr && wr_strb[2] && wr_data[FC_CLF_BIT]) || base1_wr;

   tsfc_flush_track u_ev
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .start   (ev_start),
      .done    (event_flush_done),
      .busy_q  (ev_busy),
      .req_q   (event_flush_req)
   );

   tsfc_flush_track u_dv
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .start   (dv_start),
      .done    (device_flush_done),
      .busy_q  (dv_busy),
      .req_q   (device_flush_req)
   );

   tsfc_flush_track u_cl
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .start   (cl_start),
      .done    (collection_flush_done),
      .busy_q  (cl_busy),
      .req_q   (collection_flush_req)
   );

   // ****************************************
   // read mux
   // ****************************************
   always_comb
   begin
      rd_data = '0;
      if (rd_addr == OFS_PART)
      begin
         rd_data = part_q;
      end
      else if (rd_addr == OFS_FCTL)
      begin
         rd_data              = fctl_q;
         rd_data[FC_EVF_BIT]  = ev_busy;
         rd_data[FC_DVF_BIT]  = dv_busy;
         rd_data[FC_CLF_BIT]  = cl_busy;
      end
   end

   // ****************************************
   // attribute and control outputs
   // ****************************************
   // outputs drive only this chip's service; no distribution port exists
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         partition_id            <= '0;
         perf_group              <= 1'b0;
         attr_conversion_disable <= 1'b0;
         powerdown_request       <= 1'b0;
         poison_check_en         <= 1'b0;
      end
      else
      begin
         partition_id            <= part_q[PART_ID_LSB +: PART_ID_W];
         perf_group              <= part_q[PART_PG_BIT];
         attr_conversion_disable <= fctl_q[FC_ACD_BIT];
         powerdown_request       <= fctl_q[FC_PWR_BIT];
         poison_check_en         <= fctl_q[FC_PCE_BIT];
      end
   end

   // credit fields of zero fall back to the configured counts, plus one for the normal credit count
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         normal_credit_init      <= '0;
         low_latency_credit_init <= '0;
      end
      else
      begin
         if (fctl_q[FC_NCR_LSB +: FC_NCR_W] == '0)
         begin
            normal_credit_init <= {1'b0, CFG_CREDIT} + 5'h01;
         end
         else
         begin
            normal_credit_init <= {1'b0, fctl_q[FC_NCR_LSB +: FC_NCR_W]};
         end
         if (fctl_q[FC_LLC_LSB +: FC_LLC_W] == '0)
         begin
            low_latency_credit_init <= CFG_LL_CREDIT;
         end
         else
         begin
            low_latency_credit_init <= fctl_q[FC_LLC_LSB +: FC_LLC_W];
         end
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_part_full_wr;
      wr_en && (wr_addr == OFS_PART) && (wr_strb == 4'hf);
   endsequence

   sequence s_fctl_top_wr;
      fctl_wr && wr_strb[3];
   endsequence

   sequence s_fctl_mid_wr;
      fctl_wr && wr_strb[2];
   endsequence

   AST_PART_ID: assert property (s_part_full_wr |=> ##1 partition_id == $past(wr_data[8:0], 2))
      else $error("partition id not taken from write");
   AST_PERF_GROUP: assert property (s_part_full_wr |=> ##1 perf_group == $past(wr_data[16], 2))
      else $error("monitoring group not taken from write");
   AST_IDLE_HOLD: assert property ((s_fctl_top_wr and !idle_flag) |=> ##1 $stable(attr_conversion_disable))
      else $error("idle-only field changed while busy");
   AST_ATTR_TAKE: assert property ((s_fctl_top_wr and idle_flag) |=> ##1
                                   attr_conversion_disable == $past(wr_data[31], 2))
      else $error("attribute mapping write lost while idle");
   AST_PWR_REQ: assert property (s_fctl_top_wr |=> ##1 powerdown_request == $past(wr_data[30], 2))
      else $error("power request not taken");
   AST_NCRED: assert property ((s_fctl_mid_wr and wr_data[23:20] == 4'h0) |=> ##1
                               normal_credit_init == {1'b0, CFG_CREDIT} + 5'h01)
      else $error("default normal credit wrong");
   AST_LOW_LATENCY_CREDIT_INIT: assert property ((fctl_wr && wr_strb[1] && wr_data[13:12] != 2'h0) |=> ##1
                                low_latency_credit_init == $past(wr_data[13:12], 2))
      else $error("low latency credit wrong");
   AST_POISON: assert property ((fctl_wr && wr_strb[1]) |=> ##1 poison_check_en == $past(wr_data[11], 2))
      else $error("poison check enable not taken");
   AST_EV_FLUSH: assert property ((ev_start && !ev_busy) |=> event_flush_req && ev_busy)
      else $error("event flush not started");
   AST_DV_BASE: assert property ((base0_wr && !dv_busy) |=> device_flush_req && dv_busy)
      else $error("device flush from base write missing");
   AST_CL_DONE: assert property ((cl_busy && collection_flush_done && !cl_start) |=> !cl_busy)
      else $error("collection flush status did not clear");
   AST_RSVD_ZERO: assert property ((rd_en && rd_addr == OFS_FCTL) |=> s_axi_rdata[29:24] == 6'h00
                                   && s_axi_rdata[15:14] == 2'h0 && s_axi_rdata[19] == 1'b0)
      else $error("reserved bits read non-zero");

endmodule

// file: sim/tsfc_top_bench.sv
// self-checking bench for the partition and function control registers
`timescale 1ns/1ns
module tsfc_top_bench;
   import tsfc_pkg::*;
   localparam logic [3:0] CR = 4'hf;
   localparam logic [1:0] LL = 2'h2;
   logic        aclk    = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr  = 8'h00;
   logic [7:0]  araddr  = 8'h00;
   logic [31:0] wdata   = 32'h0;
   logic [3:0]  wstrb   = 4'h0;
   logic [3:0]  ws      = 4'hf;
   logic        awvalid = 1'b0;
   logic        wvalid  = 1'b0;
   logic        bready  = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready  = 1'b0;
   logic        idle    = 1'b0;
   logic        b0      = 1'b0;
   logic        b1      = 1'b0;
   logic [2:0]  fd      = 3'h0;
   logic        awready, wready, bvalid, arready, rvalid, pg, acd, pwr, pce;
   logic [1:0]  bresp, rresp, llc;
   logic [31:0] rdata;
   logic [8:0]  pid;
   logic [4:0]  ncr;
   logic [2:0]  frq;
   int          n_mismatch = 0;
   int          n_checks   = 0;
   int          nrq[3]     = '{0, 0, 0};

   tsfc_top #(.CFG_CREDIT(CR), .CFG_LL_CREDIT(LL)) i_tsfc_top (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .idle_flag(idle), .base0_wr(b0), .base1_wr(b1),
      .event_flush_done(fd[2]), .device_flush_done(fd[1]), .collection_flush_done(fd[0]),
      .partition_id(pid), .perf_group(pg), .attr_conversion_disable(acd), .powerdown_request(pwr),
      .normal_credit_init(ncr), .low_latency_credit_init(llc), .poison_check_en(pce),
      .event_flush_req(frq[2]), .device_flush_req(frq[1]), .collection_flush_req(frq[0]));

   always #5 aclk = ~aclk;

   // counts invalidation request pulses per cache
   always @(posedge aclk)
   begin
      for (int k = 0; k < 3; k++)
         if (frq[k] === 1'b1) nrq[k]++;
   end

   task automatic end_of_test;
      if (n_mismatch == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic hang;
      n_mismatch++;
      $display("BAD %0t no bus answer", $time);
      end_of_test;
   endtask

   // ****************************************
   // bus cycles
   // ****************************************
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge aclk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wstrb   <= ws;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      n = 0;
      do
      begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         n++;
      end while (bvalid !== 1'b1 && n < 40);
      if (n >= 40) hang();
      bready <= 1'b0;
      chk(32'(bresp), 32'(er));
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      n = 0;
      do
      begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
         n++;
      end while (rvalid !== 1'b1 && n < 40);
      if (n >= 40) hang();
      rready <= 1'b0;
      chk(32'(rresp), 32'(er));
      chk(rdata, ed);
   endtask

   // control outputs in one word: acd pwr ncr llc pce
   task automatic outs(input logic [31:0] e);
      repeat (2) @(posedge aclk);
      chk({22'h0, acd, pwr, ncr, llc, pce}, e);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      rd(OFS_PART, 32'h0, RESP_OKAY);
      rd(OFS_FCTL, 32'h0, RESP_OKAY);
      outs({22'h0, 2'b00, {1'b0, CR} + 5'h01, LL, 1'b0});
   endtask

   task automatic t_part;
      wr(OFS_PART, 32'hffff_ffff, RESP_OKAY);
      rd(OFS_PART, 32'h0001_01ff, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk({22'h0, pg, pid}, 32'h0000_03ff);
      wr(OFS_PART, 32'h0000_00a5, RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk({22'h0, pg, pid}, 32'h0000_00a5);
   endtask

   task automatic t_fctl;
      wr(OFS_FCTL, 32'hfff8_ffff, RESP_OKAY);
      rd(OFS_FCTL, 32'h40f0_3800, RESP_OKAY);
      outs({22'h0, 2'b01, 5'h0f, 2'h3, 1'b1});
      idle <= 1'b1;
      wr(OFS_FCTL, 32'hfff8_ffff, RESP_OKAY);
      rd(OFS_FCTL, 32'hc0f0_3800, RESP_OKAY);
      outs({22'h0, 2'b11, 5'h0f, 2'h3, 1'b1});
      idle <= 1'b0;
      wr(OFS_FCTL, 32'h0000_0000, RESP_OKAY);
      rd(OFS_FCTL, 32'h8000_0000, RESP_OKAY);
      outs({22'h0, 2'b10, {1'b0, CR} + 5'h01, LL, 1'b0});
      idle <= 1'b1;
      wr(OFS_FCTL, 32'h0000_0000, RESP_OKAY);
      outs({22'h0, 2'b00, {1'b0, CR} + 5'h01, LL, 1'b0});
      chk(32'(nrq[0] + nrq[1] + nrq[2]), 32'h0);
   endtask

   // finishes the invalidations in mask m and expects the status to clear
   task automatic done(input logic [2:0] m);
      @(posedge aclk);
      fd <= m;
      @(posedge aclk);
      fd <= 3'h0;
      rd(OFS_FCTL, 32'h0, RESP_OKAY);
   endtask

   task automatic t_flush;
      for (int k = 2; k >= 0; k--)
      begin
         wr(OFS_FCTL, 32'h1 << (16 + k), RESP_OKAY);
         rd(OFS_FCTL, 32'h1 << (16 + k), RESP_OKAY);
         chk(32'(nrq[k]), 32'h1);
         done(3'h1 << k);
      end
      @(posedge aclk);
      b0 <= 1'b1;
      @(posedge aclk);
      b0 <= 1'b0;
      rd(OFS_FCTL, 32'h0006_0000, RESP_OKAY);
      chk(32'(nrq[2] + nrq[1]), 32'h4);
      b1 <= 1'b1;
      @(posedge aclk);
      b1 <= 1'b0;
      rd(OFS_FCTL, 32'h0007_0000, RESP_OKAY);
      chk(32'(nrq[0]), 32'h2);
      done(3'h7);
   endtask

   task automatic t_unmapped;
      wr(8'h08, 32'hffff_ffff, RESP_SLVERR);
      wr(8'h06, 32'hffff_ffff, RESP_SLVERR);
      rd(8'h08, 32'h0, RESP_SLVERR);
      rd(OFS_FCTL, 32'h0, RESP_OKAY);
   endtask

   // a start while busy adds no request; a start in the done cycle opens a new round
   task automatic t_again;
      wr(OFS_FCTL, 32'h0004_0000, RESP_OKAY);
      wr(OFS_FCTL, 32'h0004_0000, RESP_OKAY);
      @(posedge aclk);
      chk(32'(nrq[2]), 32'h3);
      fd <= 3'h4;
      b0 <= 1'b1;
      @(posedge aclk);
      fd <= 3'h0;
      b0 <= 1'b0;
      rd(OFS_FCTL, 32'h0006_0000, RESP_OKAY);
      chk(32'(nrq[2] + nrq[1]), 32'h7);
      done(3'h6);
   endtask

   // partial byte strobes touch only their own lanes
   task automatic t_lanes;
      ws = 4'h2;
      wr(OFS_FCTL, 32'hffff_ffff, RESP_OKAY);
      rd(OFS_FCTL, 32'h0000_3800, RESP_OKAY);
      chk(32'(nrq[0] + nrq[1] + nrq[2]), 32'h9);
      ws = 4'h4;
      wr(OFS_FCTL, 32'h0040_0000, RESP_OKAY);
      outs({22'h0, 2'b00, 5'h04, 2'h3, 1'b1});
      ws = 4'h1;
      wr(OFS_PART, 32'hffff_ffff, RESP_OKAY);
      rd(OFS_PART, 32'h0000_00ff, RESP_OKAY);
      ws = 4'hf;
   endtask

   // a reset in mid-run clears both registers again
   task automatic t_rerun;
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
   endtask

   initial
   begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_part();
      t_fctl();
      t_flush();
      t_again();
      t_unmapped();
      t_lanes();
      t_rerun();
      end_of_test();
   end
endmodule
